// >>> hw/burst_seq_map.svh
// Register layout, codes and reset values of the burst configuration register.
`ifndef BURST_SEQ_MAP_SVH
`define BURST_SEQ_MAP_SVH

`define CFG_WIDTH       13
`define CFG_RESET       13'h0020
`define BL_MSB          2
`define BL_LSB          0
`define BT_BIT          3
`define CL_MSB          6
`define CL_LSB          4
`define OPM_MSB         12
`define OPM_LSB         7
`define SWB_BIT         9
`define BL_CODE_1       3'h0
`define BL_CODE_2       3'h1
`define BL_CODE_4       3'h2
`define BL_CODE_8       3'h3
`define BL_CODE_PAGE    3'h7
`define CL_CODE_2       3'h2
`define CL_CODE_3       3'h3
`define OPM_BURST_WR    6'h00
`define OPM_SINGLE_WR   6'h04
`define PIN_WIDTH       19

`endif

// >>> hw/burst_seq_pkg.sv
// Types shared by the burst sequencer.
package burst_seq_pkg;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_BURST
    } seq_state_t;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_CONFIG,
        CMD_READ,
        CMD_WRITE,
        CMD_STOP
    } cmd_t;

endpackage

// >>> hw/two_entry_buffer.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module two_entry_buffer #(
    parameter int WIDTH = 10
) (
    // Clock, reset and enable
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             ce,
    // Filling side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    logic [WIDTH-1:0] head_r;
    logic [WIDTH-1:0] head_nxt;
    logic [WIDTH-1:0] tail_r;
    logic [WIDTH-1:0] tail_nxt;
    logic [1:0]       count_r;
    logic [1:0]       count_nxt;
    logic             push;
    logic             pop;
    logic             valid_r;
    logic             valid_nxt;

    assign in_ready  = (count_r != 2'h2);
    assign out_valid = valid_r;
    assign out_data  = head_r;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        head_nxt  = head_r;
        tail_nxt  = tail_r;
        count_nxt = count_r;
        if (pop)
        begin
            head_nxt = tail_r;
        end
        if (push)
        begin
            if (count_r == 2'h0 || (count_r == 2'h1 && pop))
            begin
                head_nxt = in_data;
            end
            else
            begin
                tail_nxt = in_data;
            end
        end
        if (push && !pop)
        begin
            count_nxt = count_r + 2'h1;
        end
        else if (pop && !push)
        begin
            count_nxt = count_r - 2'h1;
        end
        valid_nxt = (count_nxt != 2'h0);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            head_r  <= '0;
            tail_r  <= '0;
            count_r <= 2'h0;
            valid_r <= 1'b0;
        end
        else if (ce)
        begin
            head_r  <= head_nxt;
            tail_r  <= tail_nxt;
            count_r <= count_nxt;
            valid_r <= valid_nxt;
        end
    end

endmodule

// >>> hw/sdram_mode_burst_sequencer.sv
// Burst configuration register, column-address burst sequencer and read-latency timing.
//
// Functional notes
// RULE1: All four command strobes low loads register.
// RULE2: Controller keeps both bank selects zero.
// RULE3: Controller programs only with banks precharged.
// RULE4: Register holds contents until next load.
// RULE5: Address bits 2..0 give burst length.
// RULE6: Address bit 3 picks sequential or interleaved.
// RULE7: Address bits 6..4 give read latency.
// RULE8: Address bits 12..7 give operating mode.
// RULE9: Lengths two, four, eight in both orders.
// RULE10: Burst touches only one aligned column block.
// RULE11: Upper column bits pick block, low bits start.
// RULE12: Burst wraps inside its block at boundary.
// RULE13: Sequential order counts upward modulo burst length.
// RULE14: Interleaved order is start XOR burst counter.
// RULE15: Single-write bit makes writes one location.
// RULE16: First read data valid at edge n+m; read_oe is first sampled high at edge n+m+2.
// RULE17: Controller never programs reserved field codes.
// RULE18: Full page steps whole row until stopped.
`include "burst_seq_map.svh"
`timescale 1ns/1ps
module sdram_mode_burst_sequencer #(
    parameter int COL_W = 9
) (
    // Clock, reset and enable
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire logic               ce,
    // Command pins
    input  wire logic               cs_n,
    input  wire logic               ras_n,
    input  wire logic               cas_n,
    input  wire logic               we_n,
    input  wire logic               bank_select_low,
    input  wire logic               bank_select_high,
    input  wire logic [12:0]        addr,
    // Column stream towards the array
    output logic                    col_valid,
    input  wire logic               col_ready,
    output logic      [COL_W-1:0]   col_addr,
    output logic                    col_write,
    // Status
    output logic                    read_oe,
    output logic                    burst_active,
    output logic      [12:0]        burst_config
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser.

    logic [`PIN_WIDTH-1:0] pin_s1_r;
    logic [`PIN_WIDTH-1:0] pin_s2_r;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pin_s1_r <= '1;
            pin_s2_r <= '1;
        end
        else if (ce)
        begin
            pin_s1_r <= {cs_n, ras_n, cas_n, we_n, bank_select_high, bank_select_low, addr};
            pin_s2_r <= pin_s1_r;
        end
    end

    logic        s_cs_n;
    logic        s_ras_n;
    logic        s_cas_n;
    logic        s_we_n;
    logic [1:0]  s_bank;
    logic [12:0] s_addr;

    assign {s_cs_n, s_ras_n, s_cas_n, s_we_n, s_bank, s_addr} = pin_s2_r;

    ////////////////////////////////////////////////////////////////////////////
    // Command decode.

    burst_seq_pkg::cmd_t cmd;

    always_comb
    begin
        cmd = burst_seq_pkg::CMD_NONE;
        if (!s_cs_n)
        begin
            case ({s_ras_n, s_cas_n, s_we_n})
                3'h0:
                begin
                    if (s_bank == 2'h0)
                    begin
                        cmd = burst_seq_pkg::CMD_CONFIG; // see RULE1 see RULE2
                    end
                end
                3'h4:    cmd = burst_seq_pkg::CMD_WRITE;
                3'h5:    cmd = burst_seq_pkg::CMD_READ;
                3'h6:    cmd = burst_seq_pkg::CMD_STOP;
                default: cmd = burst_seq_pkg::CMD_NONE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Burst configuration register.

    logic [12:0] cfg_r;
    logic [12:0] cfg_nxt;

    always_comb
    begin
        cfg_nxt = cfg_r; // see RULE4
        if (cmd == burst_seq_pkg::CMD_CONFIG)
        begin
            cfg_nxt = s_addr; // see RULE1
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cfg_r <= `CFG_RESET;
        end
        else if (ce)
        begin
            cfg_r <= cfg_nxt;
        end
    end

    logic [2:0] burst_length_field;
    logic       burst_order_select;
    logic [2:0] read_latency_field;
    logic       single_write_bit;

    assign burst_length_field = cfg_r[`BL_MSB:`BL_LSB];                    // see RULE5
    assign burst_order_select = cfg_r[`BT_BIT];                            // see RULE6
    assign read_latency_field = cfg_r[`CL_MSB:`CL_LSB];                    // see RULE7
    assign single_write_bit   = (cfg_r[`OPM_MSB:`OPM_LSB] == `OPM_SINGLE_WR); // see RULE8

    ////////////////////////////////////////////////////////////////////////////
    // Burst sequencer.

    // Low-bit mask of the aligned block; a full page spans the whole row.
    logic [COL_W-1:0] len_mask;
    logic             len_page;

    always_comb
    begin
        len_mask = '0;
        len_page = 1'b0;
        case (burst_length_field) // see RULE9
            `BL_CODE_2:    len_mask = COL_W'(1);
            `BL_CODE_4:    len_mask = COL_W'(3);
            `BL_CODE_8:    len_mask = COL_W'(7);
            `BL_CODE_PAGE:
            begin
                len_mask = '1;   // see RULE18
                len_page = 1'b1;
            end
            default:       len_mask = '0;
        endcase
    end

    burst_seq_pkg::seq_state_t state_r;
    burst_seq_pkg::seq_state_t state_nxt;
    logic [COL_W-1:0] start_r;
    logic [COL_W-1:0] start_nxt;
    logic [COL_W-1:0] cnt_r;
    logic [COL_W-1:0] cnt_nxt;
    logic [COL_W-1:0] mask_r;
    logic [COL_W-1:0] mask_nxt;
    logic             page_r;
    logic             page_nxt;
    logic             ilv_r;
    logic             ilv_nxt;
    logic             wr_r;
    logic             wr_nxt;

    logic             beat_valid;
    logic             beat_ready;
    logic [COL_W-1:0] beat_low;
    logic [COL_W-1:0] beat_addr;
    logic             beat_last;
    logic             beat_fire;
    logic             is_rw;

    assign beat_valid = (state_r == burst_seq_pkg::SEQ_BURST);
    assign beat_fire  = beat_valid && beat_ready;
    assign beat_last  = !page_r && (cnt_r == mask_r);
    assign is_rw      = (cmd == burst_seq_pkg::CMD_READ) || (cmd == burst_seq_pkg::CMD_WRITE);

    always_comb
    begin
        if (ilv_r)
        begin
            beat_low = (start_r ^ cnt_r) & mask_r;   // see RULE14
        end
        else
        begin
            beat_low = (start_r + cnt_r) & mask_r;   // see RULE13 see RULE12
        end
        beat_addr = (start_r & ~mask_r) | beat_low;  // see RULE10 see RULE11
    end

    always_comb
    begin
        state_nxt = state_r;
        start_nxt = start_r;
        cnt_nxt   = cnt_r;
        mask_nxt  = mask_r;
        page_nxt  = page_r;
        ilv_nxt   = ilv_r;
        wr_nxt    = wr_r;
        if (beat_fire)
        begin
            cnt_nxt = cnt_r + COL_W'(1);
            if (beat_last)
            begin
                state_nxt = burst_seq_pkg::SEQ_IDLE;
            end
        end
        if (cmd == burst_seq_pkg::CMD_STOP)
        begin
            state_nxt = burst_seq_pkg::SEQ_IDLE; // see RULE18
        end
        else if (is_rw)
        begin
            state_nxt = burst_seq_pkg::SEQ_BURST;
            start_nxt = s_addr[COL_W-1:0];
            cnt_nxt   = '0;
            wr_nxt    = (cmd == burst_seq_pkg::CMD_WRITE);
            // A full page only runs sequentially.
            ilv_nxt   = burst_order_select && !len_page;
            if (wr_nxt && single_write_bit)
            begin
                mask_nxt = '0;   // see RULE15
                page_nxt = 1'b0;
            end
            else
            begin
                mask_nxt = len_mask;
                page_nxt = len_page;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_r <= burst_seq_pkg::SEQ_IDLE;
            start_r <= '0;
            cnt_r   <= '0;
            mask_r  <= '0;
            page_r  <= 1'b0;
            ilv_r   <= 1'b0;
            wr_r    <= 1'b0;
        end
        else if (ce)
        begin
            state_r <= state_nxt;
            start_r <= start_nxt;
            cnt_r   <= cnt_nxt;
            mask_r  <= mask_nxt;
            page_r  <= page_nxt;
            ilv_r   <= ilv_nxt;
            wr_r    <= wr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Column buffer towards the array.

    logic [COL_W:0] buf_out;

    two_entry_buffer #(
        .WIDTH (COL_W + 1)
    ) u_col_buf (
        .clk       (clk),
        .srst      (srst),
        .ce        (ce),
        .in_valid  (beat_valid),
        .in_ready  (beat_ready),
        .in_data   ({wr_r, beat_addr}),
        .out_valid (col_valid),
        .out_ready (col_ready),
        .out_data  (buf_out)
    );

    assign col_write = buf_out[COL_W];
    assign col_addr  = buf_out[COL_W-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Read-latency timing.

    logic read_beat;
    logic rd_pipe_r;
    logic rd_pipe_nxt;
    logic read_oe_r;
    logic read_oe_nxt;
    logic active_r;
    logic active_nxt;

    assign read_beat = beat_fire && !wr_r;

    always_comb
    begin
        rd_pipe_nxt = read_beat;
        if (read_latency_field == `CL_CODE_3)
        begin
            read_oe_nxt = rd_pipe_r;   // see RULE16
        end
        else
        begin
            read_oe_nxt = read_beat;   // see RULE16
        end
        active_nxt = (state_nxt == burst_seq_pkg::SEQ_BURST);
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rd_pipe_r <= 1'b0;
            read_oe_r <= 1'b0;
            active_r  <= 1'b0;
        end
        else if (ce)
        begin
            rd_pipe_r <= rd_pipe_nxt;
            read_oe_r <= read_oe_nxt;
            active_r  <= active_nxt;
        end
    end

    assign read_oe      = read_oe_r;
    assign burst_active = active_r;
    assign burst_config = cfg_r;

endmodule

// >>> dv/burst_seq_checker.sv
// Port checks for the burst sequencer.
`timescale 1ns/1ps
module burst_seq_checker #(
    parameter int COL_W = 9
) (
    // Clock and reset
    input wire logic             clk,
    input wire logic             srst,
    // Command pins
    input wire logic             cs_n,
    input wire logic             ras_n,
    input wire logic             cas_n,
    input wire logic             we_n,
    input wire logic             bank_select_low,
    input wire logic             bank_select_high,
    input wire logic [12:0]      addr,
    // Stream and status
    input wire logic             col_valid,
    input wire logic             col_ready,
    input wire logic [COL_W-1:0] col_addr,
    input wire logic             col_write,
    input wire logic             read_oe,
    input wire logic             burst_active,
    input wire logic [12:0]      burst_config
);
    wire mrs = !cs_n && !ras_n && !cas_n && !we_n && !bank_select_low && !bank_select_high;
    wire rd = !cs_n && ras_n && !cas_n && we_n;
    wire wr = !cs_n && ras_n && !cas_n && !we_n;
    wire idle = !burst_active && !col_valid;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_cfg_load;
        mrs |-> ##3 burst_config == $past(addr, 3);
    endproperty
    a_cfg_load: assert property (p_cfg_load) else $error("config not loaded");
    property p_cfg_hold;
        $changed(burst_config) |-> $past(mrs, 3) || $past(srst);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed");
    property p_lat2;
        rd && idle && burst_config[6:4] == 3'h2 |-> ##3 !read_oe ##1 read_oe;
    endproperty
    a_lat2: assert property (p_lat2) else $error("latency two wrong");
    property p_lat3;
        rd && idle && burst_config[6:4] == 3'h3 |-> ##4 !read_oe ##1 read_oe;
    endproperty
    a_lat3: assert property (p_lat3) else $error("latency three wrong");
    property p_len4;
        rd && idle && burst_config[2:0] == 3'h2 |-> ##3 burst_active[*4] ##1 !burst_active;
    endproperty
    a_len4: assert property (p_len4) else $error("length four wrong");
    property p_single;
        wr && idle && burst_config[12:7] == 6'h04 |-> ##3 burst_active ##1 !burst_active;
    endproperty
    a_single: assert property (p_single) else $error("single write wrong");
    property p_first;
        rd && idle |-> ##4 col_valid && !col_write && col_addr == $past(addr[COL_W-1:0], 4);
    endproperty
    a_first: assert property (p_first) else $error("first beat wrong");
    property p_wr_oe;
        wr && idle |-> ##1 !read_oe [*6];
    endproperty
    a_wr_oe: assert property (p_wr_oe) else $error("output window on write");
    property p_hold;
        col_valid && !col_ready |=> col_valid && $stable(col_addr) && $stable(col_write);
    endproperty
    a_hold: assert property (p_hold) else $error("beat lost");

    c_page: cover property (burst_active && burst_config[2:0] == 3'h7);
    c_stall: cover property (col_valid && !col_ready ##1 col_valid && col_ready);
    c_lat3: cover property (read_oe && burst_config[6:4] == 3'h3);
endmodule

bind sdram_mode_burst_sequencer burst_seq_checker #(.COL_W(COL_W)) chk_u (
    .clk(clk), .srst(srst), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank_select_low(bank_select_low), .bank_select_high(bank_select_high), .addr(addr),
    .col_valid(col_valid), .col_ready(col_ready), .col_addr(col_addr),
    .col_write(col_write), .read_oe(read_oe), .burst_active(burst_active),
    .burst_config(burst_config)
);

// >>> dv/ctrl_model.sv
// Behavioural memory controller driving the command pins.
`timescale 1ns/1ps
module ctrl_model (
    // Clock
    input  wire logic  clk,
    // Command pins
    output logic       cs_n,
    output logic       ras_n,
    output logic       cas_n,
    output logic       we_n,
    output logic       bank_select_low,
    output logic       bank_select_high,
    output logic [12:0] addr
);
    initial
    begin
        {cs_n, ras_n, cas_n, we_n} = 4'hF;
        {bank_select_high, bank_select_low} = 2'h3;
        addr = 13'h1555;
    end

    // One command for one clock, then deselect with scrambled address lines.
    task issue(input logic [3:0] pins, input logic [1:0] bank, input logic [12:0] a);
        @(posedge clk);
        #1;
        {cs_n, ras_n, cas_n, we_n} = pins;
        {bank_select_high, bank_select_low} = bank;
        addr = a;
        @(posedge clk);
        #1;
        {cs_n, ras_n, cas_n, we_n} = 4'hF;
        {bank_select_high, bank_select_low} = ~bank;
        addr = ~a;
    endtask

    // Register set with both bank selects low; clock enable stays high.
    task set_config(input logic [12:0] a);
        issue(4'h0, 2'h0, a);
    endtask
endmodule

// >>> dv/tb_sdram_mode_burst_sequencer.sv
// Self-checking bench for the burst sequencer.
`timescale 1ns/1ps
module tb_sdram_mode_burst_sequencer;
    logic        clk, srst, col_ready, col_valid, col_write, read_oe, burst_active;
    logic        cs_n, ras_n, cas_n, we_n, bank_select_low, bank_select_high;
    logic [12:0] addr, burst_config;
    logic [8:0]  col_addr;
    int          n_mismatch = 0;
    int          total_checks = 0;

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ctrl_model ctl_u (.clk(clk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .bank_select_low(bank_select_low), .bank_select_high(bank_select_high), .addr(addr));
    sdram_mode_burst_sequencer #(.COL_W(9)) dut_u (.clk(clk), .srst(srst), .ce(1'b1),
        .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .bank_select_low(bank_select_low), .bank_select_high(bank_select_high), .addr(addr),
        .col_valid(col_valid), .col_ready(col_ready), .col_addr(col_addr),
        .col_write(col_write), .read_oe(read_oe), .burst_active(burst_active),
        .burst_config(burst_config));

    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task chk(input logic [12:0] got, input logic [12:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task cfg(input logic [12:0] a);
        ctl_u.set_config(a);
        repeat (3) @(posedge clk);
        #2;
        chk(burst_config, a, "config");
    endtask

    // Issues a read or write and follows its first n beats; stall holds the stream back first.
    task burst(input logic [3:0] pins, input logic [8:0] start, input int len, input int n,
               input logic ilv, input logic stall);
        int         k;
        int         i;
        logic [8:0] m;
        logic [8:0] exp;
        k = 0;
        m = 9'(len - 1);
        ctl_u.issue(pins, 2'h0, {4'h0, start});
        col_ready = !stall;
        if (stall)
        begin
            repeat (14) @(posedge clk);
            #1;
            chk(13'(burst_active), 13'h1, "stalled");
            col_ready = 1'b1;
        end
        // The head is judged before the edge that takes it, so a standing beat is seen once.
        for (i = 0; i < 40 && k < n; i++)
        begin
            if (col_valid === 1'b1)
            begin
                exp = (start & ~m) | ((ilv ? start ^ 9'(k) : start + 9'(k)) & m);
                chk(13'(col_addr), 13'(exp), "column");
                chk(13'(col_write), 13'(pins == 4'h4), "direction");
                k++;
            end
            @(posedge clk);
            #2;
        end
        if (k < n)
        begin
            n_mismatch++;
            $display("MISMATCH %0t beats missing", $time);
            end_of_test;
        end
        if (n == len)
        begin
            repeat (4) @(posedge clk);
            #2;
            chk(13'(col_valid), 13'h0, "extra beat");
        end
        repeat (6) @(posedge clk);
    endtask

    task t_config;
        int b;
        cfg(13'h0033);
        for (b = 1; b < 4; b++)
        begin
            ctl_u.issue(4'h0, 2'(b), 13'h0022);
            repeat (3) @(posedge clk);
            #2;
            chk(burst_config, 13'h0033, "other register");
        end
    endtask

    task t_orders;
        int c;
        int t;
        for (c = 0; c < 4; c++)
        begin
            for (t = 0; t < 2; t++)
            begin
                cfg({6'h00, 3'h2, 1'(t), 3'(c)});
                burst(4'h5, 9'h1F2 + 9'(5 * c + t), 1 << c, 1 << c, 1'(t), 1'b0);
            end
        end
    endtask

    task t_modes;
        cfg({6'h04, 3'h3, 1'b0, 3'h3});
        burst(4'h4, 9'h0F5, 1, 1, 1'b0, 1'b0);
        burst(4'h5, 9'h0F5, 8, 8, 1'b0, 1'b0);
        cfg({6'h00, 3'h3, 1'b1, 3'h2});
        burst(4'h4, 9'h0F5, 4, 4, 1'b1, 1'b0);
        cfg(13'h0030);
        burst(4'h5, 9'h0AA, 1, 1, 1'b0, 1'b0);
    endtask

    task t_stall_page;
        cfg({6'h00, 3'h2, 1'b0, 3'h3});
        burst(4'h5, 9'h13D, 8, 8, 1'b0, 1'b1);
        cfg({6'h00, 3'h2, 1'b0, 3'h7});
        burst(4'h5, 9'h1FE, 512, 6, 1'b0, 1'b0);
        ctl_u.issue(4'h6, 2'h0, 13'h0000);
        repeat (4) @(posedge clk);
        #2;
        chk(13'(burst_active), 13'h0, "page stop");
    endtask

    initial
    begin
        srst = 1'b1;
        col_ready = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        srst = 1'b0;
        #1;
        chk(burst_config, 13'h0020, "reset config");
        chk(13'({col_valid, read_oe, burst_active}), 13'h0, "reset outputs");
        t_config;
        t_orders;
        t_modes;
        t_stall_page;
        end_of_test;
    end
endmodule
